// File: rtl/cssch_adapter.sv
// Line adapter end: line registers, request flags and character exchange
`timescale 1ns/1ps
`default_nettype none
module cssch_adapter (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  cssch_link_if.adapter    link,
  input  wire logic        rx_in_valid,
  input  wire logic [2:0]  rx_in_line,
  input  wire logic [7:0]  rx_in_char,
  input  wire logic [15:0] modem_in,
  output logic             tx_out_valid,
  output logic [2:0]       tx_out_line,
  output logic [7:0]       tx_out_char,
  output logic [7:0]       line_enabled,
  output logic [7:0][7:0]  line_config,
  output logic [7:0][7:0]  line_control,
  output logic [15:0][7:0] chan_speed
);

  typedef struct packed {
    logic [15:0]      req;
    logic [7:0]       enabled;
    logic [7:0][7:0]  rx_char;
    logic [7:0][7:0]  config_r;
    logic [7:0][7:0]  control;
    logic [15:0][7:0] speed;
    logic [15:0]      status;
    logic             tx_valid;
    logic [2:0]       tx_line;
    logic [7:0]       tx_char;
  } cssch_adp_type;

  cssch_adp_type cur;
  cssch_adp_type next_cur;

  // Next state of the adapter
  always_comb begin
    next_cur          = cur;
    next_cur.tx_valid = 1'b0;
    next_cur.status   = modem_in;
    // Grant clears a request; a same-cycle set below wins
    if (link.svc_ack) begin
      next_cur.req[link.svc_chan] = 1'b0;
    end
    if (link.lreg_wr) begin
      if (link.lreg_sel == cssch_pkg::LREG_CONFIG) begin
        next_cur.config_r[link.lreg_chan[3:1]] = link.lreg_data;
      end else if (link.lreg_sel == cssch_pkg::LREG_SPEED) begin
        next_cur.speed[link.lreg_chan] = link.lreg_data;
      end else if (link.lreg_sel == cssch_pkg::LREG_CONTROL) begin
        next_cur.control[link.lreg_chan[3:1]] = link.lreg_data;
        next_cur.enabled[link.lreg_chan[3:1]] = 1'b1;
        next_cur.req[{link.lreg_chan[3:1], 1'b1}] = 1'b1;
      end else if (link.lreg_sel == cssch_pkg::LREG_DATA && link.lreg_chan[0]) begin
        next_cur.tx_valid = 1'b1;
        next_cur.tx_line  = link.lreg_chan[3:1];
        next_cur.tx_char  = link.lreg_data;
        next_cur.req[link.lreg_chan] = 1'b1;
      end
    end
    if (rx_in_valid && cur.enabled[rx_in_line]) begin
      next_cur.rx_char[rx_in_line] = rx_in_char;
      next_cur.req[{rx_in_line, 1'b0}] = 1'b1;
    end
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Outputs
  assign link.chan_req     = cur.req;
  assign link.rx_char      = cur.rx_char;
  assign link.modem_status = cur.status;
  assign tx_out_valid      = cur.tx_valid;
  assign tx_out_line       = cur.tx_line;
  assign tx_out_char       = cur.tx_char;
  assign line_enabled      = cur.enabled;
  assign line_config       = cur.config_r;
  assign line_control      = cur.control;
  assign chan_speed        = cur.speed;

endmodule : cssch_adapter
`default_nettype wire

// File: rtl/cssch_link_if.sv
// Link between the scheduler and the line adapters
`timescale 1ns/1ps
`default_nettype none
interface cssch_link_if;
  logic [15:0]      chan_req;
  logic             svc_ack;
  logic [3:0]       svc_chan;
  logic             lreg_wr;
  logic [3:0]       lreg_chan;
  logic [2:0]       lreg_sel;
  logic [7:0]       lreg_data;
  logic [7:0][7:0]  rx_char;
  logic [15:0]      modem_status;

  // Scheduler end
  modport sched (
    input  chan_req,
    input  rx_char,
    input  modem_status,
    output svc_ack,
    output svc_chan,
    output lreg_wr,
    output lreg_chan,
    output lreg_sel,
    output lreg_data
  );

  // Line adapter end
  modport adapter (
    output chan_req,
    output rx_char,
    output modem_status,
    input  svc_ack,
    input  svc_chan,
    input  lreg_wr,
    input  lreg_chan,
    input  lreg_sel,
    input  lreg_data
  );
endinterface : cssch_link_if
`default_nettype wire

// File: rtl/cssch_pkg.sv
// Package of shared constants, layouts and state codes for the channel service scheduler
package cssch_pkg;

  // Channel and line counts, character and address widths
  localparam int unsigned NUM_CHAN   = 16;
  localparam int unsigned NUM_LINE   = 8;
  localparam int unsigned CHAR_W     = 8;
  localparam int unsigned ADDR_W     = 12;

  // Local RAM layout: line tables low, channel programs, control blocks high
  localparam logic [11:0] LINE_TABLE_BASE  = 12'h000;
  localparam logic [11:0] LINE_TABLE_BYTES = 12'h040;
  localparam logic [11:0] LINE_TABLE_HALF  = 12'h020;
  localparam logic [11:0] PROG_BASE        = 12'h200;
  localparam logic [11:0] PROG_BYTES       = 12'hc00;
  localparam logic [11:0] TCB_BASE         = 12'he00;
  localparam logic [11:0] TCB_BYTES        = 12'h008;
  localparam logic [11:0] TCB_PER_CHAN     = 12'h004;

  // Line register selectors
  localparam logic [2:0] LREG_DATA    = 3'h1;
  localparam logic [2:0] LREG_CONTROL = 3'h2;
  localparam logic [2:0] LREG_SPEED   = 3'h4;
  localparam logic [2:0] LREG_CONFIG  = 3'h6;

  // Background scan period
  localparam longint unsigned CLK_HZ         = 50000000;
  localparam longint unsigned SCAN_PERIOD_MS = 500;
  localparam int unsigned     SCAN_CYCLES    = 32'((CLK_HZ / 1000) * SCAN_PERIOD_MS);

  // Scheduler states
  typedef enum logic [3:0] {
    CSSCH_IDLE     = 4'b0000,
    CSSCH_LOAD_CFG = 4'b0001,
    CSSCH_LOAD_SPD = 4'b0010,
    CSSCH_LOAD_CTL = 4'b0011,
    CSSCH_RX_LOAD  = 4'b0100,
    CSSCH_RX_EDIT  = 4'b0101,
    CSSCH_RX_STORE = 4'b0110,
    CSSCH_TX_FETCH = 4'b0111,
    CSSCH_TX_SEND  = 4'b1000
  } cssch_state_type;

  function automatic logic [11:0] cssch_line_table_addr(input logic [3:0] chan);
    cssch_line_table_addr = LINE_TABLE_BASE + LINE_TABLE_BYTES * {9'h000, chan[3:1]}
                            + (chan[0] ? LINE_TABLE_HALF : 12'h000);
  endfunction : cssch_line_table_addr

  function automatic logic [11:0] cssch_tcb_addr(input logic [3:0] chan, input logic [1:0] idx);
    cssch_tcb_addr = TCB_BASE + TCB_BYTES * (TCB_PER_CHAN * {8'h00, chan} + {10'h000, idx});
  endfunction : cssch_tcb_addr

  // Lowest numbered pending channel
  function automatic logic [3:0] cssch_first_set(input logic [15:0] vec);
    cssch_first_set = 4'h0;
    for (int i = NUM_CHAN - 1; i >= 0; i--) begin
      if (vec[i]) begin
        cssch_first_set = 4'(i);
      end
    end
  endfunction : cssch_first_set

endpackage : cssch_pkg

// File: rtl/cssch_scheduler.sv
// Channel service scheduler: host starts, channel service, background status scan
`timescale 1ns/1ps
`default_nettype none
module cssch_scheduler #(
  parameter int unsigned SCAN_CYCLES = cssch_pkg::SCAN_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  cssch_link_if.sched      link,
  input  wire logic        host_start_valid,
  output logic             host_start_ready,
  input  wire logic [3:0]  host_start_chan,
  input  wire logic [7:0]  cfg_format,
  input  wire logic [7:0]  cfg_speed,
  input  wire logic [7:0]  cfg_control,
  input  wire logic [7:0]  edit_mask,
  input  wire logic [15:0] scan_irq_en,
  input  wire logic [15:0] scan_start_en,
  output logic             store_valid,
  output logic [3:0]       store_chan,
  output logic [11:0]      store_tcb_addr,
  output logic [7:0]       store_char,
  output logic             fetch_valid,
  output logic [3:0]       fetch_chan,
  output logic [11:0]      fetch_tcb_addr,
  input  wire logic        fetch_ready,
  input  wire logic [7:0]  fetch_char,
  output logic             host_irq,
  output logic [3:0]       host_irq_chan,
  output logic [11:0]      host_irq_table_addr,
  output logic [15:0]      chan_running,
  output logic             scan_busy
);

  localparam int unsigned SCAN_W = $clog2(SCAN_CYCLES + 1);
  localparam logic [SCAN_W-1:0] SCAN_LAST = SCAN_W'(SCAN_CYCLES - 1);

  typedef struct packed {
    cssch_pkg::cssch_state_type st;
    logic [3:0]        chan;
    logic [7:0]        work;
    logic [15:0]       running;
    logic [15:0]       last_status;
    logic [3:0]        scan_idx;
    logic              scan_due;
    logic [SCAN_W-1:0] scan_cnt;
    logic              ack;
    logic              lreg_wr;
    logic [2:0]        lreg_sel;
    logic [7:0]        lreg_data;
    logic              store_valid;
    logic [11:0]       tcb_addr;
    logic              irq;
    logic [3:0]        irq_chan;
  } cssch_sched_type;

  cssch_sched_type cur;
  cssch_sched_type next_cur;
  logic            idle;
  logic            any_req;
  logic [3:0]      top_chan;
  logic            status_change;

  // Grant selection and status scan inputs
  assign idle     = (cur.st == cssch_pkg::CSSCH_IDLE);
  assign any_req  = |link.chan_req;
  assign top_chan = cssch_pkg::cssch_first_set(link.chan_req);
  assign status_change = link.modem_status[cur.scan_idx] != cur.last_status[cur.scan_idx];

  // Next state of the scheduler
  always_comb begin
    next_cur             = cur;
    next_cur.ack         = 1'b0;
    next_cur.lreg_wr     = 1'b0;
    next_cur.store_valid = 1'b0;
    next_cur.irq         = 1'b0;
    if (cur.scan_cnt == SCAN_LAST) begin
      next_cur.scan_cnt = '0;
      next_cur.scan_due = 1'b1;
    end else begin
      next_cur.scan_cnt = cur.scan_cnt + SCAN_W'(1);
    end
    case (cur.st)
      cssch_pkg::CSSCH_IDLE: begin
        if (host_start_valid) begin
          next_cur.chan = host_start_chan;
          next_cur.st   = cssch_pkg::CSSCH_LOAD_CFG;
        end else if (any_req) begin
          next_cur.ack      = 1'b1;
          next_cur.chan     = top_chan;
          next_cur.tcb_addr = cssch_pkg::cssch_tcb_addr(top_chan, 2'h0);
          if (top_chan[0]) begin
            next_cur.st = cssch_pkg::CSSCH_TX_FETCH;
          end else begin
            next_cur.st = cssch_pkg::CSSCH_RX_LOAD;
          end
        end else if (cur.scan_due) begin
          next_cur.last_status[cur.scan_idx] = link.modem_status[cur.scan_idx];
          next_cur.scan_idx                  = cur.scan_idx + 4'h1;
          // A new period landing on the last visit keeps the sweep due
          if (cur.scan_idx == 4'hf && cur.scan_cnt != SCAN_LAST) begin
            next_cur.scan_due = 1'b0;
          end
          if (status_change && scan_irq_en[cur.scan_idx]) begin
            next_cur.irq      = 1'b1;
            next_cur.irq_chan = cur.scan_idx;
          end else if (status_change && scan_start_en[cur.scan_idx]) begin
            next_cur.chan = cur.scan_idx;
            next_cur.st   = cssch_pkg::CSSCH_LOAD_CFG;
          end
        end
      end
      cssch_pkg::CSSCH_LOAD_CFG: begin
        next_cur.lreg_wr   = 1'b1;
        next_cur.lreg_sel  = cssch_pkg::LREG_CONFIG;
        next_cur.lreg_data = cfg_format;
        next_cur.st        = cssch_pkg::CSSCH_LOAD_SPD;
      end
      cssch_pkg::CSSCH_LOAD_SPD: begin
        next_cur.lreg_wr   = 1'b1;
        next_cur.lreg_sel  = cssch_pkg::LREG_SPEED;
        next_cur.lreg_data = cfg_speed;
        next_cur.st        = cssch_pkg::CSSCH_LOAD_CTL;
      end
      cssch_pkg::CSSCH_LOAD_CTL: begin
        next_cur.lreg_wr            = 1'b1;
        next_cur.lreg_sel           = cssch_pkg::LREG_CONTROL;
        next_cur.lreg_data          = cfg_control;
        next_cur.running[cur.chan]  = 1'b1;
        next_cur.st                 = cssch_pkg::CSSCH_IDLE;
      end
      cssch_pkg::CSSCH_RX_LOAD: begin
        next_cur.work = link.rx_char[cur.chan[3:1]];
        next_cur.st   = cssch_pkg::CSSCH_RX_EDIT;
      end
      cssch_pkg::CSSCH_RX_EDIT: begin
        next_cur.work        = cur.work ^ edit_mask;
        next_cur.store_valid = 1'b1;
        next_cur.st          = cssch_pkg::CSSCH_RX_STORE;
      end
      // store strobe out this cycle, then back to idle
      cssch_pkg::CSSCH_RX_STORE: begin
        next_cur.st = cssch_pkg::CSSCH_IDLE;
      end
      cssch_pkg::CSSCH_TX_FETCH: begin
        if (fetch_ready) begin
          next_cur.work = fetch_char ^ edit_mask;
          next_cur.st   = cssch_pkg::CSSCH_TX_SEND;
        end
      end
      cssch_pkg::CSSCH_TX_SEND: begin
        next_cur.lreg_wr   = 1'b1;
        next_cur.lreg_sel  = cssch_pkg::LREG_DATA;
        next_cur.lreg_data = cur.work;
        next_cur.st        = cssch_pkg::CSSCH_IDLE;
      end
      default: begin
        next_cur.st = cssch_pkg::CSSCH_IDLE;
      end
    endcase
  end

  // State register
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // Handshakes
  assign host_start_ready = idle;
  assign fetch_valid      = (cur.st == cssch_pkg::CSSCH_TX_FETCH);

  // Link outputs
  assign link.svc_ack   = cur.ack;
  assign link.svc_chan  = cur.chan;
  assign link.lreg_wr   = cur.lreg_wr;
  assign link.lreg_chan = cur.chan;
  assign link.lreg_sel  = cur.lreg_sel;
  assign link.lreg_data = cur.lreg_data;

  // Host side outputs
  assign store_valid         = cur.store_valid;
  assign store_chan          = cur.chan;
  assign store_tcb_addr      = cur.tcb_addr;
  assign store_char          = cur.work;
  assign fetch_chan          = cur.chan;
  assign fetch_tcb_addr      = cur.tcb_addr;
  assign host_irq            = cur.irq;
  assign host_irq_chan       = cur.irq_chan;
  assign host_irq_table_addr = cssch_pkg::cssch_line_table_addr(cur.irq_chan);
  assign chan_running        = cur.running;
  assign scan_busy           = cur.scan_due;

endmodule : cssch_scheduler
`default_nettype wire

// File: verification/channel_service_scheduler_tb_top.sv
// Bench joining scheduler and adapter over the link
`timescale 1ns/1ps
`default_nettype none
module channel_service_scheduler_tb_top;
  typedef struct packed {
    logic [3:0] chan;
    logic [7:0] fmt;
    logic [7:0] spd;
    logic [7:0] ctl;
  } cssch_row_type;

  logic             ref_clk, arst_n, host_start_valid, host_start_ready, fetch_ready, rx_in_valid;
  logic             store_valid, fetch_valid, host_irq, scan_busy, tx_out_valid;
  logic [3:0]       host_start_chan, store_chan, fetch_chan, host_irq_chan;
  logic [7:0]       cfg_format, cfg_speed, cfg_control, edit_mask, fetch_char, rx_in_char;
  logic [7:0]       store_char, tx_out_char, line_enabled;
  logic [15:0]      scan_irq_en, scan_start_en, modem_in, chan_running;
  logic [2:0]       rx_in_line, tx_out_line;
  logic [11:0]      store_tcb_addr, fetch_tcb_addr, host_irq_table_addr;
  logic [7:0][7:0]  line_config, line_control;
  logic [15:0][7:0] chan_speed;
  int               mismatches, total_checks;
  logic [3:0]       stores[$], irqs[$], acks[$];
  cssch_row_type    rows[4];

  cssch_link_if link ();
  cssch_scheduler #(.SCAN_CYCLES(64)) cssch_scheduler_i (
    .ref_clk, .arst_n, .link, .host_start_valid, .host_start_ready, .host_start_chan, .cfg_format,
    .cfg_speed, .cfg_control, .edit_mask, .scan_irq_en, .scan_start_en, .store_valid, .store_chan,
    .store_tcb_addr, .store_char, .fetch_valid, .fetch_chan, .fetch_tcb_addr, .fetch_ready, .fetch_char,
    .host_irq, .host_irq_chan, .host_irq_table_addr, .chan_running, .scan_busy);
  cssch_adapter cssch_adapter_i (
    .ref_clk, .arst_n, .link, .rx_in_valid, .rx_in_line, .rx_in_char, .modem_in, .tx_out_valid,
    .tx_out_line, .tx_out_char, .line_enabled, .line_config, .line_control, .chan_speed);
  cssch_link_chk cssch_link_chk_i (
    .ref_clk, .arst_n, .chan_req(link.chan_req), .svc_ack(link.svc_ack), .svc_chan(link.svc_chan),
    .lreg_wr(link.lreg_wr), .lreg_chan(link.lreg_chan), .lreg_sel(link.lreg_sel));

  always #10 ref_clk = ~ref_clk;

  task automatic check_ok(input logic ok, input string what);
    total_checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("Error at %0t: %s", $time, what);
    end
  endtask : check_ok

  task automatic finish_test;
    if (mismatches == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : finish_test

  task automatic timeout(input int n, input int lim);
    if (n >= lim) begin
      mismatches++;
      $display("Error at %0t: wait limit", $time);
      finish_test();
    end
  endtask : timeout

  // Record grants, stores and interrupts; check characters and addresses
  always @(posedge ref_clk) begin
    if (link.svc_ack === 1'b1) begin
      acks.push_back(link.svc_chan);
    end
    if (store_valid === 1'b1) begin
      stores.push_back(store_chan);
      check_ok(store_char === ((8'h30 + {5'h00, store_chan[3:1]}) ^ edit_mask), "stored char");
      check_ok(store_tcb_addr === {3'h7, store_chan, 5'h00}, "block address");
    end
    if (host_irq === 1'b1) begin
      irqs.push_back(host_irq_chan);
      check_ok(host_irq_table_addr === {3'h0, host_irq_chan, 5'h00}, "table address");
    end
    if (tx_out_valid === 1'b1) begin
      check_ok(tx_out_char === (fetch_char ^ edit_mask) && line_enabled[tx_out_line] === 1'b1, "sent char");
    end
    if (fetch_valid === 1'b1 && fetch_ready === 1'b1) begin
      check_ok(fetch_chan[0] === 1'b1 && fetch_tcb_addr === {3'h7, fetch_chan, 5'h00}, "fetch block");
    end
  end

  // Host start of one channel, watching the three line register writes
  task automatic start_chan(input cssch_row_type r);
    logic [2:0] sel[3];
    logic [7:0] dat[3];
    int         n;
    sel = '{cssch_pkg::LREG_CONFIG, cssch_pkg::LREG_SPEED, cssch_pkg::LREG_CONTROL};
    dat = '{r.fmt, r.spd, r.ctl};
    n = 0;
    {host_start_chan, cfg_format, cfg_speed, cfg_control} = r;
    host_start_valid = 1'b1;
    while (host_start_ready !== 1'b1 && n < 400) begin
      @(negedge ref_clk);
      n++;
    end
    timeout(n, 400);
    @(negedge ref_clk);
    host_start_valid = 1'b0;
    for (int k = 0; k < 3; k++) begin
      @(negedge ref_clk);
      check_ok(link.lreg_wr === 1'b1 && link.lreg_chan === r.chan && link.lreg_sel === sel[k] &&
               link.lreg_data === dat[k], "line register write");
    end
    repeat (2) @(negedge ref_clk);
    check_ok(line_config[r.chan[3:1]] === r.fmt && line_control[r.chan[3:1]] === r.ctl &&
             chan_speed[r.chan] === r.spd && line_enabled[r.chan[3:1]] === 1'b1 &&
             chan_running[r.chan] === 1'b1, "line registers");
  endtask : start_chan

  // Reset, scan, table of starts, then precedence and priority
  initial begin
    int n;
    {ref_clk, arst_n, host_start_valid, host_start_chan} = 7'h00;
    {cfg_format, cfg_speed, cfg_control, edit_mask, fetch_char} = 40'h0000005a3c;
    {scan_irq_en, scan_start_en, modem_in} = 48'h0008_0020_0000;
    {fetch_ready, rx_in_valid, rx_in_line, rx_in_char} = 13'h1000;
    {mismatches, total_checks} = 64'h0;
    rows = '{'{4'h0, 8'h11, 8'h12, 8'h13}, '{4'h3, 8'h21, 8'h22, 8'h23},
             '{4'h2, 8'h31, 8'h32, 8'h33}, '{4'he, 8'h41, 8'h42, 8'h43}};
    repeat (6) @(negedge ref_clk);
    arst_n = 1'b1;
    check_ok(host_start_ready === 1'b1 && chan_running === 16'h0000 && link.chan_req === 16'h0000 &&
             scan_busy === 1'b0, "reset");
    modem_in = 16'h0228;
    n = 0;
    while (chan_running[5] !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    timeout(n, 300);
    repeat (20) @(negedge ref_clk);
    check_ok(irqs.size() == 1 && irqs[0] === 4'h3 && chan_running === 16'h0020, "scan actions");
    foreach (rows[i]) begin
      start_chan(rows[i]);
    end
    fetch_ready = 1'b0;
    n = 0;
    while (fetch_valid !== 1'b1 && n < 100) begin
      @(negedge ref_clk);
      n++;
    end
    timeout(n, 100);
    for (int l = 1; l >= 0; l--) begin
      {rx_in_valid, rx_in_line, rx_in_char} = {1'b1, 3'(l), 8'h30 + 8'(l)};
      @(negedge ref_clk);
    end
    rx_in_valid = 1'b0;
    @(negedge ref_clk);
    check_ok(link.chan_req[0] === 1'b1 && link.chan_req[2] === 1'b1, "requests waiting");
    acks.delete();
    fetch_ready = 1'b1;
    start_chan('{4'h4, 8'h51, 8'h52, 8'h53});
    // Start-up ran first; channel 0 took the first idle cycle after it
    check_ok(acks.size() == 1 && acks[0] === 4'h0 && stores.size() == 0, "host start first");
    n = 0;
    while (acks.size() < 4 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    timeout(n, 300);
    // Channel 1 asks again one cycle after the scheduler is free, so channel 2 goes in between
    check_ok(acks[0] === 4'h0 && acks[1] === 4'h1 && acks[2] === 4'h2 && acks[3] === 4'h1, "order");
    check_ok(stores.size() == 2 && stores[0] === 4'h0 && stores[1] === 4'h2 &&
             link.chan_req[3] === 1'b1, "rx served, others held");
    finish_test();
  end
endmodule : channel_service_scheduler_tb_top
`default_nettype wire

// File: verification/cssch_link_chk.sv
// Link checker: grants, requests and line register writes
`timescale 1ns/1ps
`default_nettype none
module cssch_link_chk (
  input wire logic        ref_clk,
  input wire logic        arst_n,
  input wire logic [15:0] chan_req,
  input wire logic        svc_ack,
  input wire logic [3:0]  svc_chan,
  input wire logic        lreg_wr,
  input wire logic [3:0]  lreg_chan,
  input wire logic [2:0]  lreg_sel
);
  logic [15:0] prev_req;
  logic [7:0]  line_on;
  logic [15:0] on_mask;

  default clocking cb_main @(posedge ref_clk); endclocking
  default disable iff (!arst_n);

  // Previous requests and lines whose control register is loaded
  always_ff @(posedge ref_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_req <= 16'h0000;
      line_on  <= 8'h00;
    end else begin
      prev_req <= chan_req;
      if (lreg_wr && lreg_sel == cssch_pkg::LREG_CONTROL) begin
        line_on[lreg_chan[3:1]] <= 1'b1;
      end
    end
  end

  // Both channels of an enabled line may request
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      on_mask[i] = line_on[i / 2];
    end
  end

  property p_ack_pulse;
    svc_ack |=> !svc_ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("grant longer than one cycle");
  property p_ack_pending;
    svc_ack |-> prev_req[svc_chan];
  endproperty
  a_ack_pending: assert property (p_ack_pending) else $error("grant without request");
  property p_prio;
    svc_ack |-> (prev_req & ((16'h0001 << svc_chan) - 16'h0001)) == 16'h0000;
  endproperty
  a_prio: assert property (p_prio) else $error("lower channel passed over");
  property p_req_hold;
    |(prev_req & ~chan_req) |-> $past(svc_ack) && (prev_req & ~chan_req) == (16'h0001 << $past(svc_chan));
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request dropped before grant");
  property p_order;
    lreg_wr && lreg_sel == cssch_pkg::LREG_CONFIG |=> lreg_wr && lreg_sel == cssch_pkg::LREG_SPEED
      && $stable(lreg_chan) ##1 lreg_wr && lreg_sel == cssch_pkg::LREG_CONTROL && $stable(lreg_chan);
  endproperty
  a_order: assert property (p_order) else $error("start-up write order");
  property p_no_grant_busy;
    (lreg_wr |-> !svc_ack) and (svc_ack |=> !svc_ack ##1 !svc_ack);
  endproperty
  a_no_grant_busy: assert property (p_no_grant_busy) else $error("grant while program busy");
  property p_tx_odd;
    lreg_wr && lreg_sel == cssch_pkg::LREG_DATA |-> lreg_chan[0];
  endproperty
  a_tx_odd: assert property (p_tx_odd) else $error("data write to receive channel");
  property p_silent;
    (chan_req & ~on_mask) == 16'h0000;
  endproperty
  a_silent: assert property (p_silent) else $error("request on disabled line");

  c_rx_grant: cover property (svc_ack && !svc_chan[0]);
  c_tx_write: cover property (lreg_wr && lreg_sel == cssch_pkg::LREG_DATA);
  c_startup: cover property (lreg_wr && lreg_sel == cssch_pkg::LREG_CONTROL);
endmodule : cssch_link_chk
`default_nettype wire
